/* design/lvds_pixel_serializer.sv */
// parallel pixel word to serial lane transmitter with forwarded clock lane
// Summary of operation
// - The wide variant takes a 28-bit word of eight red, eight green, eight blue and four control bits.
// - The narrow variant takes a 21-bit word of six red, six green, six blue and three control bits.
// - Line sync, frame sync and data valid travel unchanged beside the colour bits.
// - The word leaves on four data lanes in the wide variant and three in the narrow one.
// - A clock at the pixel rate leaves on its own lane in step with the data lanes.
// - A bit clock seven times the pixel rate shifts seven bits per lane each pixel period.
// - The pixel word is sampled on the pixel clock edge picked by the strobe-edge select.
// - Strobe-edge select high captures on the rising pixel clock edge.
// - Strobe-edge select low or open captures on the falling pixel clock edge.
// - An open strobe-edge select reads low, so falling-edge capture is the default.
// - While power-down is low every lane output is released to high impedance.
// - After the clock is steady and power-down released, outputs wait for lock of up to 10 ms.
// - Outputs are released within 100 ns of power-down going low.
`timescale 1ns/1ps
module lvds_pixel_serializer #(
  parameter int unsigned WORD_BITS = lvds_pixel_pkg::WORD_BITS_WIDE,
  parameter int unsigned LOCK_CYCLES = lvds_pixel_pkg::LOCK_CYCLES_DEFAULT,
  parameter int unsigned BIT_MAP [28] = '{
    0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13,
    14, 15, 16, 17, 18, 19, 20, 21, 22, 23, 24, 25, 26, 27}
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pixelClockPin,
  input wire logic strobeEdgeSelect,
  input wire logic powerDownN,
  input wire lvds_pixel_pkg::pixel_word_t pixelIn,
  output lvds_pixel_pkg::lane_out_t laneOut,
  output logic laneOe
);
  import lvds_pixel_pkg::*;

  localparam int unsigned LANES = WORD_BITS / SLOTS_PER_PIXEL;
  localparam int unsigned COLOR_BITS = (WORD_BITS == WORD_BITS_WIDE) ? 8 : 6;
  localparam int unsigned PIN_W = $bits(pixel_word_t) + 3;

  if (WORD_BITS != WORD_BITS_WIDE && WORD_BITS != WORD_BITS_NARROW) begin : g_check
    $error("lvds_pixel_serializer: WORD_BITS must be 28 or 21");
  end

  // every used map entry must point into the word
  for (genvar i = 0; i < LANES * SLOTS_PER_PIXEL; i++) begin : g_map_check
    if (BIT_MAP[i] >= WORD_BITS) begin : g_bad
      $error("lvds_pixel_serializer: bit map entry out of range");
    end
  end

  // ---- pin synchronisers: everything from outside passes two flops
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] meta_r, meta_nxt;
  logic [PIN_W-1:0] sync_r, sync_nxt;
  pixel_word_t syncWord;
  logic syncPixClk, syncSelect, syncPdN;

  always_comb begin
    pins = {pixelIn, pixelClockPin, strobeEdgeSelect, powerDownN};
    meta_nxt = pins;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  always_comb begin
    syncWord = sync_r[PIN_W-1 -: $bits(pixel_word_t)];
    syncPixClk = sync_r[2];
    syncSelect = sync_r[1];
    syncPdN = sync_r[0];
  end

  // ---- edge detection and word capture
  logic prevPixClk_r, prevPixClk_nxt;
  logic [WORD_BITS-1:0] word;
  logic [WORD_BITS-1:0] wordDly_r, wordDly_nxt;
  logic [WORD_BITS-1:0] hold_r, hold_nxt;
  logic riseEdge, fallEdge, captureEdge;

  always_comb begin
    word = '0;
    word[COLOR_BITS-1:0] = syncWord.red[COLOR_BITS-1:0];
    word[2*COLOR_BITS-1 -: COLOR_BITS] = syncWord.green[COLOR_BITS-1:0];
    word[3*COLOR_BITS-1 -: COLOR_BITS] = syncWord.blue[COLOR_BITS-1:0];
    word[3*COLOR_BITS] = syncWord.lineSync;
    word[3*COLOR_BITS+1] = syncWord.frameSync;
    word[3*COLOR_BITS+2] = syncWord.pixelValid;
    if (WORD_BITS == WORD_BITS_WIDE) begin
      word[WORD_BITS-1] = syncWord.spareCtrl;
    end
    riseEdge = syncPixClk && !prevPixClk_r;
    fallEdge = !syncPixClk && prevPixClk_r;
    // low, and an open pin pulled low outside, selects the falling edge
    captureEdge = syncSelect ? riseEdge : fallEdge;
    prevPixClk_nxt = syncPixClk;
    // word seen one cycle before the edge was noticed, i.e. before the edge
    wordDly_nxt = word;
    hold_nxt = captureEdge ? wordDly_r : hold_r;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prevPixClk_r <= 1'b0;
      wordDly_r <= '0;
      hold_r <= '0;
    end else begin
      prevPixClk_r <= prevPixClk_nxt;
      wordDly_r <= wordDly_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ---- bit clock multiplier
  logic bitTick;
  logic locked;

  bit_clock_multiplier #(
    .PERIOD_W(PERIOD_COUNT_BITS),
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_mult (
    .clk(clk),
    .rstn(rstn),
    .run(syncPdN),
    .refEdge(riseEdge),
    .bitTick(bitTick),
    .locked(locked)
  );

  // ---- slot counter, one frame of seven slots per pixel
  logic [6:0] slot_r, slot_nxt;
  logic frameLoad;
  logic shiftStep;

  always_comb begin
    frameLoad = bitTick && (slot_r == SLOT_RESET);
    shiftStep = bitTick && !frameLoad;
    slot_nxt = slot_r;
    if (!locked) begin
      slot_nxt = SLOT_RESET;
    end else if (frameLoad) begin
      slot_nxt = '0;
    end else if (bitTick) begin
      slot_nxt = slot_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slot_r <= SLOT_RESET;
    end else begin
      slot_r <= slot_nxt;
    end
  end

  // ---- data lane shifters, slot 0 leaves first
  logic [MAX_DATA_LANES-1:0] laneBit;

  for (genvar ln = 0; ln < MAX_DATA_LANES; ln++) begin : g_lane
    logic [6:0] shift_r, shift_nxt;
    if (ln < LANES) begin : g_used
      always_comb begin
        shift_nxt = shift_r;
        if (!locked) begin
          shift_nxt = '0;
        end else if (frameLoad) begin
          for (int s = 0; s < 7; s++) begin
            shift_nxt[6-s] = hold_r[BIT_MAP[ln*7+s]];
          end
        end else if (shiftStep) begin
          shift_nxt = {shift_r[5:0], 1'b0};
        end
      end
    end else begin : g_unused
      always_comb begin
        shift_nxt = '0;
      end
    end
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        shift_r <= '0;
      end else begin
        shift_r <= shift_nxt;
      end
    end
    assign laneBit[ln] = shift_r[6];
  end

  // ---- forwarded clock lane, same framing as the data lanes
  logic [6:0] clkShift_r, clkShift_nxt;

  always_comb begin
    clkShift_nxt = clkShift_r;
    if (!locked) begin
      clkShift_nxt = '0;
    end else if (frameLoad) begin
      clkShift_nxt = CLOCK_LANE_PATTERN;
    end else if (shiftStep) begin
      clkShift_nxt = {clkShift_r[5:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkShift_r <= '0;
    end else begin
      clkShift_r <= clkShift_nxt;
    end
  end

  // ---- outputs; enable follows the second sync flop, two edges after the pin
  always_comb begin
    laneOut.dataLanes = laneBit;
    laneOut.clockLane = clkShift_r[6];
    laneOe = syncPdN;
  end

endmodule

/* design/lvds_pixel_pkg.sv */
// shared constants and carrier types for the pixel link transmitter
package lvds_pixel_pkg;

  // serial frame
  localparam int unsigned SLOTS_PER_PIXEL = 7;
  localparam logic [6:0] CLOCK_LANE_PATTERN = 7'h63;
  localparam int unsigned WORD_BITS_WIDE = 28;
  localparam int unsigned WORD_BITS_NARROW = 21;
  localparam int unsigned MAX_DATA_LANES = 4;
  localparam int unsigned MAX_COLOR_BITS = 8;

  // timing at the system clock
  localparam int unsigned CLK_FREQ_KHZ = 20000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned POWER_DOWN_DELAY_NS = 100;
  localparam int unsigned POWER_DOWN_DELAY_CYCLES =
    (POWER_DOWN_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 : POWER_DOWN_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned LOCK_TIME_MS = 10;
  localparam int unsigned LOCK_CYCLES_DEFAULT = LOCK_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned PERIOD_COUNT_BITS = 8;

  // reset values
  localparam logic [6:0] SLOT_RESET = 7'h06;

  typedef struct packed {
    logic spareCtrl;
    logic pixelValid;
    logic frameSync;
    logic lineSync;
    logic [MAX_COLOR_BITS-1:0] blue;
    logic [MAX_COLOR_BITS-1:0] green;
    logic [MAX_COLOR_BITS-1:0] red;
  } pixel_word_t;

  typedef struct packed {
    logic [MAX_DATA_LANES-1:0] dataLanes;
    logic clockLane;
  } lane_out_t;

endpackage

/* design/bit_clock_multiplier.sv */
// measures the pixel period and spreads seven bit ticks over each period
`timescale 1ns/1ps
module bit_clock_multiplier #(
  parameter int unsigned PERIOD_W = lvds_pixel_pkg::PERIOD_COUNT_BITS,
  parameter int unsigned LOCK_CYCLES = lvds_pixel_pkg::LOCK_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic refEdge,
  output logic bitTick,
  output logic locked
);
  import lvds_pixel_pkg::*;

  localparam int unsigned LOCK_W = $clog2(LOCK_CYCLES + 1);
  localparam logic [PERIOD_W:0] SLOTS = (PERIOD_W + 1)'(SLOTS_PER_PIXEL);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES);

  if (PERIOD_W < 3 || LOCK_CYCLES < 1) begin : g_check
    $error("bit_clock_multiplier: unusable parameters");
  end

  logic [PERIOD_W-1:0] cnt_r, cnt_nxt;
  logic [PERIOD_W-1:0] period_r, period_nxt;
  logic [PERIOD_W:0] acc_r, acc_nxt;
  logic [LOCK_W-1:0] lockCnt_r, lockCnt_nxt;
  logic locked_r, locked_nxt;
  logic [PERIOD_W:0] accSum;
  logic stalled;
  logic tick;

  always_comb begin
    stalled = (cnt_r == '1);
    accSum = acc_r + SLOTS;
    tick = locked_r && (accSum >= {1'b0, period_r});
    cnt_nxt = stalled ? cnt_r : cnt_r + 1'b1;
    period_nxt = period_r;
    if (refEdge) begin
      cnt_nxt = {{(PERIOD_W-1){1'b0}}, 1'b1};
      period_nxt = cnt_r;
    end
    // any drift, stop or power-down drops lock
    lockCnt_nxt = lockCnt_r;
    locked_nxt = locked_r;
    if (!run || stalled || (refEdge && cnt_r != period_r)) begin
      lockCnt_nxt = '0;
      locked_nxt = 1'b0;
    end else if (lockCnt_r != LOCK_LAST) begin
      lockCnt_nxt = lockCnt_r + 1'b1;
    end else begin
      locked_nxt = 1'b1;
    end
    // seven ticks per measured period
    if (!locked_r) begin
      acc_nxt = '0;
    end else if (tick) begin
      acc_nxt = accSum - {1'b0, period_r};
    end else begin
      acc_nxt = accSum;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      period_r <= '0;
      acc_r <= '0;
      lockCnt_r <= '0;
      locked_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      period_r <= period_nxt;
      acc_r <= acc_nxt;
      lockCnt_r <= lockCnt_nxt;
      locked_r <= locked_nxt;
    end
  end

  assign bitTick = tick;
  assign locked = locked_r;

endmodule

/* sim/lane_link_checker_sva.sv */
// pin-level assertions for the pixel link transmitter
`timescale 1ns/1ps
module lane_link_checker #(
  parameter int unsigned LOCK_CYCLES = 64
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic powerDownN,
  input wire lvds_pixel_pkg::lane_out_t laneOut,
  input wire logic laneOe
);
  import lvds_pixel_pkg::*;
  int unsigned upCount_r;
  int unsigned upCount_nxt;
  logic steady;
  logic prevClk_r;
  logic framed_r;
  logic framed_nxt;
  // cycles of steady power since power-down or reset
  assign upCount_nxt = !powerDownN ? 0 : upCount_r + (upCount_r < LOCK_CYCLES);
  // first frame after lock shows only half a clock run, so skip its rise
  assign framed_nxt = powerDownN && (framed_r || (laneOut.clockLane && !prevClk_r));
  assign steady = (upCount_r == LOCK_CYCLES) && framed_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upCount_r <= 0;
      prevClk_r <= 1'b0;
      framed_r <= 1'b0;
    end else begin
      upCount_r <= upCount_nxt;
      prevClk_r <= laneOut.clockLane;
      framed_r <= framed_nxt;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_oe_off: assert property (!powerDownN [*3] |-> !laneOe)
    else $error("lanes enabled in power-down");
  chk_oe_on: assert property (powerDownN [*3] |-> laneOe)
    else $error("lanes not enabled");
  chk_oe_cause: assert property ($fell(laneOe) |-> !$past(powerDownN, 2))
    else $error("lanes disabled without power-down");
  chk_lanes_quiet: assert property (laneOut != '0 |-> $past(powerDownN, 6))
    else $error("lanes active after power-down");
  chk_lock_wait: assert property (upCount_r >= 8 && upCount_r < LOCK_CYCLES |->
    laneOut == '0) else $error("lanes active before lock");
  chk_clk_high: assert property ($rose(laneOut.clockLane) && steady |->
    laneOut.clockLane [*4]) else $error("clock lane high too short");
  chk_clk_low: assert property ($fell(laneOut.clockLane) && steady |->
    !laneOut.clockLane [*3]) else $error("clock lane low too short");
  chk_frame_rate: assert property ($rose(laneOut.clockLane) && steady |=>
    !$rose(laneOut.clockLane) [*6]) else $error("frames closer than seven cycles");
  cover property (laneOut.dataLanes != '0);
  cover property ($fell(laneOe));
  cover property ($rose(laneOe));
endmodule
bind lvds_pixel_serializer lane_link_checker #(.LOCK_CYCLES(LOCK_CYCLES)) linkCheck (
  .clk(clk), .rstn(rstn), .powerDownN(powerDownN), .laneOut(laneOut), .laneOe(laneOe));

/* sim/pixel_source.sv */
// controller model: free-running pixel clock, words set up around each edge
`timescale 1ns/1ps
module pixel_source (
  input wire lvds_pixel_pkg::pixel_word_t wordRise,
  input wire lvds_pixel_pkg::pixel_word_t wordFall,
  output logic pixelClockPin,
  output lvds_pixel_pkg::pixel_word_t pixelIn
);
  import lvds_pixel_pkg::*;
  initial begin
    pixelClockPin = 1'b0;
    pixelIn = '0;
    #37;
    forever begin
      // each word is centred on the edge it belongs to
      #100 pixelIn = wordFall;
      #100 pixelClockPin = 1'b0;
      #100 pixelIn = wordRise;
      #100 pixelClockPin = 1'b1;
    end
  end
endmodule

/* sim/tb_lvds_pixel_serializer.sv */
// self-checking bench for the pixel link transmitter
`timescale 1ns/1ps
module tb_lvds_pixel_serializer;
  import lvds_pixel_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic strobeEdgeSelect = 1'b0;
  logic powerDownN = 1'b1;
  logic pixelClockPin;
  logic laneOe;
  pixel_word_t pixelIn;
  pixel_word_t wordRise = '0;
  pixel_word_t wordFall = '0;
  lane_out_t laneOut;
  lane_out_t laneOutNarrow;
  logic laneOeNarrow;
  int failures = 0;
  int totalChecks = 0;
  always #25 clk = ~clk;
  pixel_source src (.wordRise(wordRise), .wordFall(wordFall),
    .pixelClockPin(pixelClockPin), .pixelIn(pixelIn));
  lvds_pixel_serializer #(.LOCK_CYCLES(64)) uut (.clk(clk), .rstn(rstn),
    .pixelClockPin(pixelClockPin), .strobeEdgeSelect(strobeEdgeSelect),
    .powerDownN(powerDownN), .pixelIn(pixelIn), .laneOut(laneOut), .laneOe(laneOe));
  lvds_pixel_serializer #(.WORD_BITS(21), .LOCK_CYCLES(64)) uutNarrow (.clk(clk), .rstn(rstn),
    .pixelClockPin(pixelClockPin), .strobeEdgeSelect(strobeEdgeSelect),
    .powerDownN(powerDownN), .pixelIn(pixelIn), .laneOut(laneOutNarrow),
    .laneOe(laneOeNarrow));
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input logic got, input logic exp);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: flag %b", $time, got);
    end
  endtask
  task automatic check_lanes(input lane_out_t got, input lane_out_t exp);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: lanes %h not %h", $time, got, exp);
    end
  endtask
  function automatic lane_out_t slot_val(input logic [27:0] w, input int lanes, input int s);
    lane_out_t v;
    v = '0;
    for (int l = 0; l < lanes; l++) begin
      v.dataLanes[l] = w[l * 7 + s];
    end
    v.clockLane = CLOCK_LANE_PATTERN[6 - s];
    return v;
  endfunction
  // narrow word: six bits per colour, then line, frame, valid
  function automatic logic [27:0] narrow_word(input pixel_word_t w);
    return {7'h0, w.pixelValid, w.frameSync, w.lineSync, w.blue[5:0], w.green[5:0], w.red[5:0]};
  endfunction
  // eight samples from slot 2 on; one slot shows twice where the tick idles
  task automatic check_frame(input pixel_word_t w);
    lane_out_t seen [8];
    lane_out_t seenNarrow [8];
    logic hit;
    logic hitNarrow;
    logic ok;
    logic okNarrow;
    int n;
    int s;
    for (n = 0; n < 40 && laneOut.clockLane !== 1'b1; n++) cycles(1);
    for (n = 0; n < 40 && laneOut.clockLane !== 1'b0; n++) cycles(1);
    for (int i = 0; i < 8; i++) begin
      seen[i] = laneOut;
      seenNarrow[i] = laneOutNarrow;
      cycles(1);
    end
    ok = 1'b0;
    okNarrow = 1'b0;
    for (int k = 0; k < 7; k++) begin
      hit = 1'b1;
      hitNarrow = 1'b1;
      for (int i = 0; i < 8; i++) begin
        s = ((i > k ? i - 1 : i) + 2) % 7;
        if (seen[i] !== slot_val(w, 4, s)) hit = 1'b0;
        if (seenNarrow[i] !== slot_val(narrow_word(w), 3, s)) hitNarrow = 1'b0;
      end
      ok = ok | hit;
      okNarrow = okNarrow | hitNarrow;
    end
    check(ok, 1'b1);
    check(okNarrow, 1'b1);
  endtask
  task automatic test_reset();
    cycles(2);
    check(laneOe, 1'b0);
    check_lanes(laneOut, '0);
    rstn = 1'b1;
    cycles(3);
    check(laneOe, 1'b1);
    $display("test_reset done");
  endtask
  task automatic test_lock_idle();
    repeat (60) begin
      check_lanes(laneOut, '0);
      cycles(1);
    end
    $display("test_lock_idle done");
  endtask
  task automatic test_edge(input logic sel, input pixel_word_t a, input pixel_word_t b);
    strobeEdgeSelect = sel;
    wordRise = a;
    wordFall = b;
    cycles(50);
    check_frame(sel ? a : b);
    $display("test_edge done");
  endtask
  task automatic test_power_down();
    powerDownN = 1'b0;
    cycles(2);
    check(laneOe, 1'b0);
    check(laneOeNarrow, 1'b0);
    cycles(4);
    check_lanes(laneOut, '0);
    powerDownN = 1'b1;
    cycles(3);
    check(laneOe, 1'b1);
    repeat (50) begin
      check_lanes(laneOut, '0);
      cycles(1);
    end
    $display("test_power_down done");
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    test_reset();
    test_lock_idle();
    test_edge(1'b1, 28'h5a3c96e, 28'hba5c3f1);
    test_edge(1'b0, 28'h5a3c96e, 28'hba5c3f1);
    test_edge(1'b0, 28'h1000000, 28'he0000ff);
    test_power_down();
    test_edge(1'b1, 28'h7000f0f, 28'h0);
    final_report();
  end
  initial begin
    #60000;
    failures++;
    final_report();
  end
endmodule
